// [chg_defs.svh]
// register offsets, reset values, field positions and timing counts for the charger bank
`ifndef CHG_DEFS_SVH
`define CHG_DEFS_SVH

`define CHG_ADDR_VLIM      8'h04
`define CHG_ADDR_CTL1      8'h05
`define CHG_ADDR_CTL2      8'h06
`define CHG_ADDR_CTL3      8'h07

`define CHG_RST_VLIM       8'h40
`define CHG_RST_CTL1       8'h9E
`define CHG_RST_CTL2       8'hE6
`define CHG_RST_CTL3       8'h4C

// bits of 07h that the watchdog restores (7, 6, 2)
`define CHG_CTL3_WD_MASK   8'hC4

// field positions
`define CHG_VCODE_HI       7
`define CHG_VCODE_LO       3
`define CHG_TOPUP_HI       2
`define CHG_TOPUP_LO       1
`define CHG_RECHG_BIT      0
`define CHG_TERM_BIT       7
`define CHG_WD_HI          5
`define CHG_WD_LO          4
`define CHG_SAFE_BIT       3
`define CHG_FAST_BIT       2
`define CHG_WARM_BIT       0
`define CHG_OVP_HI         7
`define CHG_OVP_LO         6
`define CHG_VIN_HI         3
`define CHG_VIN_LO         0

// analog targets, in millivolts
`define CHG_CHARGE_REGULATION_VOLTAGE_BASE_MV   13'd4300
`define CHG_CHARGE_REGULATION_VOLTAGE_STEP_MV   13'd10
`define CHG_CHARGE_REGULATION_VOLTAGE_LIN_CODE  5'd9
`define CHG_WARM_MAX_MV    13'd4100
`define CHG_RECHG_LO_MV    8'd120
`define CHG_RECHG_HI_MV    8'd210
`define CHG_VIN_BASE_MV    13'd3900
`define CHG_VIN_STEP_MV    13'd100

// timing: watchdog base tick of one second at a 10 ns clock
`define CHG_WD_TICK_MS     1000
`define CHG_CLK_PERIOD_NS  10
`define CHG_WD_TICK_CYCLES ((`CHG_WD_TICK_MS * 1000000) / `CHG_CLK_PERIOD_NS)
`define CHG_PRECHG_HOURS   5'd2
`define CHG_FAST_LONG_H    5'd20
`define CHG_FAST_SHORT_H   5'd10

`endif

// [chg_pkg.sv]
// types shared by the charger configuration bank
package chg_pkg;

  // decoded configuration fields
  typedef struct packed {
    logic [4:0] charge_voltage_code;
    logic [1:0] topup_duration_select;
    logic       recharge_threshold_select;
    logic       term_enable;
    logic [1:0] watchdog_select;
    logic       safety_timer_enable;
    logic       fast_charge_timer_select;
    logic       warm_zone_voltage_select;
    logic [1:0] input_overvoltage_select;
    logic [3:0] input_voltage_limit;
  } chg_cfg_t;

  // analog targets and durations derived from the fields
  typedef struct packed {
    logic [12:0] charge_regulation_voltage;
    logic [12:0] warm_charge_voltage;
    logic [7:0]  recharge_drop_mv;
    logic [5:0]  topup_minutes;
    logic [7:0]  watchdog_seconds;
    logic [4:0]  precharge_hours;
    logic [4:0]  fast_charge_hours;
    logic [14:0] overvoltage_mv;
    logic [12:0] input_limit_mv;
  } chg_target_t;

  // register-port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } chg_req_t;

endpackage : chg_pkg

// [chg_config_bank.sv]
// configuration registers 04h-07h of the charger with host watchdog
`timescale 1ns/1ns
`include "chg_defs.svh"

module chg_config_bank #(
  parameter int unsigned TICK_CYCLES = `CHG_WD_TICK_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire chg_pkg::chg_req_t req,
  output logic [7:0]             rdata,
  output logic                   rvalid,
  input  wire logic              host_timeout_restart,
  output logic                   host_timeout_restart_clr,
  output logic                   watchdog_expired,
  output logic                   watchdog_fault,
  output chg_pkg::chg_cfg_t      cfg,
  output chg_pkg::chg_target_t   target
);

  // charge voltage code to millivolts
  function automatic logic [12:0] charge_regulation_voltage_mv(input logic [4:0] code);
    logic [12:0] mv;
    mv = 13'd0;
    case (code)
      5'h00:   mv = 13'd3504;
      5'h01:   mv = 13'd3600;
      5'h02:   mv = 13'd3696;
      5'h03:   mv = 13'd3800;
      5'h04:   mv = 13'd3904;
      5'h05:   mv = 13'd4000;
      5'h06:   mv = 13'd4100;
      5'h07:   mv = 13'd4150;
      5'h08:   mv = 13'd4200;
      default: mv = 13'(`CHG_CHARGE_REGULATION_VOLTAGE_BASE_MV + `CHG_CHARGE_REGULATION_VOLTAGE_STEP_MV * 13'(code - `CHG_CHARGE_REGULATION_VOLTAGE_LIN_CODE));
    endcase
    return mv;
  endfunction : charge_regulation_voltage_mv

  // watchdog field to seconds, zero when disabled
  function automatic logic [7:0] wd_seconds(input logic [1:0] sel);
    logic [7:0] s;
    s = 8'h00;
    case (sel)
      2'h1:    s = 8'd40;
      2'h2:    s = 8'd80;
      2'h3:    s = 8'd160;
      default: s = 8'h00;
    endcase
    return s;
  endfunction : wd_seconds

  logic [7:0]  vlim_reg, vlim_next;
  logic [7:0]  ctl1_reg, ctl1_next;
  logic [7:0]  ctl2_reg, ctl2_next;
  logic [7:0]  ctl3_reg, ctl3_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] tick_reg, tick_next;
  logic [7:0]  sec_reg, sec_next;
  logic        clr_reg, clr_next;
  logic        exp_reg, exp_next;
  logic        fault_reg, fault_next;
  logic [7:0]  period_s;
  logic        tick_done;
  logic        expire;
  logic        restart;

  // watchdog period and expiry detection
  assign period_s  = wd_seconds(ctl1_reg[`CHG_WD_HI:`CHG_WD_LO]);
  assign tick_done = (tick_reg == TICK_CYCLES - 1);
  assign restart   = host_timeout_restart && !clr_reg;
  assign expire    = (period_s != 8'h00) && tick_done && (sec_reg == period_s - 8'h01) && !restart;

  // watchdog counters, restart acknowledge and fault flag
  always_comb begin
    tick_next  = tick_reg;
    sec_next   = sec_reg;
    clr_next   = 1'b0;
    exp_next   = 1'b0;
    fault_next = fault_reg;
    if (period_s == 8'h00 || restart) begin
      tick_next = 32'h0;
      sec_next  = 8'h00;
    end else if (tick_done) begin
      tick_next = 32'h0;
      sec_next  = expire ? 8'h00 : sec_reg + 8'h01;
    end else begin
      tick_next = tick_reg + 32'h1;
    end
    if (restart) begin
      clr_next   = 1'b1;
      fault_next = 1'b0;
    end
    if (expire) begin
      exp_next   = 1'b1;
      fault_next = 1'b1;
    end
  end

  // register file: host writes, watchdog restores defaults of 04h, 05h and bits 7, 6, 2 of 07h, keeps 06h
  always_comb begin
    vlim_next = vlim_reg;
    ctl1_next = ctl1_reg;
    ctl2_next = ctl2_reg;
    ctl3_next = ctl3_reg;
    if (req.wr) begin
      case (req.addr)
        `CHG_ADDR_VLIM: vlim_next = req.wdata;
        `CHG_ADDR_CTL1: ctl1_next = req.wdata;
        `CHG_ADDR_CTL2: ctl2_next = req.wdata;
        `CHG_ADDR_CTL3: ctl3_next = req.wdata;
        default: ;
      endcase
    end
    if (expire) begin
      vlim_next = `CHG_RST_VLIM;
      ctl1_next = `CHG_RST_CTL1;
      ctl3_next = (ctl3_next & ~`CHG_CTL3_WD_MASK) | (`CHG_RST_CTL3 & `CHG_CTL3_WD_MASK);
    end
  end

  // read path, unmapped addresses read zero
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = req.rd;
    if (req.rd) begin
      case (req.addr)
        `CHG_ADDR_VLIM: rdata_next = vlim_reg;
        `CHG_ADDR_CTL1: rdata_next = ctl1_reg;
        `CHG_ADDR_CTL2: rdata_next = ctl2_reg;
        `CHG_ADDR_CTL3: rdata_next = ctl3_reg;
        default:        rdata_next = 8'h00;
      endcase
    end
  end

  // state registers, frozen while ce is low unless rst_n is low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vlim_reg   <= `CHG_RST_VLIM;
      ctl1_reg   <= `CHG_RST_CTL1;
      ctl2_reg   <= `CHG_RST_CTL2;
      ctl3_reg   <= `CHG_RST_CTL3;
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
      tick_reg   <= 32'h0;
      sec_reg    <= 8'h00;
      clr_reg    <= 1'b0;
      exp_reg    <= 1'b0;
      fault_reg  <= 1'b0;
    end else if (ce) begin
      vlim_reg   <= vlim_next;
      ctl1_reg   <= ctl1_next;
      ctl2_reg   <= ctl2_next;
      ctl3_reg   <= ctl3_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      tick_reg   <= tick_next;
      sec_reg    <= sec_next;
      clr_reg    <= clr_next;
      exp_reg    <= exp_next;
      fault_reg  <= fault_next;
    end
  end

  // registered values onto the ports
  assign rdata                    = rdata_reg;
  assign rvalid                   = rvalid_reg;
  assign host_timeout_restart_clr = clr_reg;
  assign watchdog_expired         = exp_reg;
  assign watchdog_fault           = fault_reg;

  // field decode
  always_comb begin
    cfg.charge_voltage_code       = vlim_reg[`CHG_VCODE_HI:`CHG_VCODE_LO];
    cfg.topup_duration_select     = vlim_reg[`CHG_TOPUP_HI:`CHG_TOPUP_LO];
    cfg.recharge_threshold_select = vlim_reg[`CHG_RECHG_BIT];
    cfg.term_enable               = ctl1_reg[`CHG_TERM_BIT];
    cfg.watchdog_select           = ctl1_reg[`CHG_WD_HI:`CHG_WD_LO];
    cfg.safety_timer_enable       = ctl1_reg[`CHG_SAFE_BIT];
    cfg.fast_charge_timer_select  = ctl1_reg[`CHG_FAST_BIT];
    cfg.warm_zone_voltage_select  = ctl1_reg[`CHG_WARM_BIT];
    cfg.input_overvoltage_select  = ctl2_reg[`CHG_OVP_HI:`CHG_OVP_LO];
    cfg.input_voltage_limit       = ctl2_reg[`CHG_VIN_HI:`CHG_VIN_LO];
  end

  // analog targets and durations, zero means function off
  always_comb begin
    target.charge_regulation_voltage = charge_regulation_voltage_mv(cfg.charge_voltage_code);
    if (cfg.warm_zone_voltage_select || target.charge_regulation_voltage < `CHG_WARM_MAX_MV) begin
      target.warm_charge_voltage = target.charge_regulation_voltage;
    end else begin
      target.warm_charge_voltage = `CHG_WARM_MAX_MV;
    end
    target.recharge_drop_mv = cfg.recharge_threshold_select ? `CHG_RECHG_HI_MV : `CHG_RECHG_LO_MV;
    target.topup_minutes    = 6'(6'd15 * {4'h0, cfg.topup_duration_select});
    target.watchdog_seconds = period_s;
    target.precharge_hours  = cfg.safety_timer_enable ? `CHG_PRECHG_HOURS : 5'd0;
    if (!cfg.safety_timer_enable) begin
      target.fast_charge_hours = 5'd0;
    end else if (cfg.fast_charge_timer_select) begin
      target.fast_charge_hours = `CHG_FAST_SHORT_H;
    end else begin
      target.fast_charge_hours = `CHG_FAST_LONG_H;
    end
    case (cfg.input_overvoltage_select)
      2'h0:    target.overvoltage_mv = 15'd5850;
      2'h1:    target.overvoltage_mv = 15'd6400;
      2'h2:    target.overvoltage_mv = 15'd11000;
      default: target.overvoltage_mv = 15'd14200;
    endcase
    target.input_limit_mv = 13'(`CHG_VIN_BASE_MV + `CHG_VIN_STEP_MV * {9'h0, cfg.input_voltage_limit});
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_restart_seen;
    ce && restart;
  endsequence

  sequence s_clear_pulse;
    host_timeout_restart_clr ##1 !host_timeout_restart_clr;
  endsequence

  a_reset_defaults: assert property (
    $rose(rst_n) |-> vlim_reg == `CHG_RST_VLIM && ctl1_reg == `CHG_RST_CTL1
                     && ctl2_reg == `CHG_RST_CTL2 && ctl3_reg == `CHG_RST_CTL3)
    else $error("registers not at defaults after reset");

  a_write_vlim: assert property (
    ce && req.wr && req.addr == `CHG_ADDR_VLIM && !expire |=> vlim_reg == $past(req.wdata))
    else $error("write to 04h not stored");

  a_linear_code: assert property (
    cfg.charge_voltage_code >= 5'd9 |->
      target.charge_regulation_voltage == 13'd4300 + 13'd10 * 13'(cfg.charge_voltage_code - 5'd9))
    else $error("charge voltage not linear above code 9");

  a_warm_limit: assert property (
    !cfg.warm_zone_voltage_select |-> target.warm_charge_voltage <= 13'd4100)
    else $error("warm zone voltage above 4.1 V");

  a_expiry_defaults: assert property (
    ce && expire |=> vlim_reg == `CHG_RST_VLIM && ctl1_reg == `CHG_RST_CTL1 && watchdog_expired && watchdog_fault)
    else $error("watchdog expiry did not restore defaults");

  a_ctl2_kept: assert property (
    ce && expire && !(req.wr && req.addr == `CHG_ADDR_CTL2) |=> $stable(ctl2_reg))
    else $error("06h changed on watchdog expiry");

  a_restart_ack: assert property (
    s_restart_seen |=> s_clear_pulse)
    else $error("restart not acknowledged by a one cycle clear");

  a_wd_disabled: assert property (
    ce && cfg.watchdog_select == 2'h0 |-> !expire ##1 sec_reg == 8'h00)
    else $error("disabled watchdog still counting");

  a_restart_zero: assert property (
    s_restart_seen |=> sec_reg == 8'h00 && tick_reg == 32'h0 && !watchdog_fault)
    else $error("restart did not clear the watchdog");

  a_vin_limit: assert property (
    cfg.input_voltage_limit == 4'h6 |-> target.input_limit_mv == 13'd4500)
    else $error("input limit code 6 not 4.5 V");

  a_write_ctl1: assert property (
    ce && req.wr && req.addr == `CHG_ADDR_CTL1 && !expire |=> ctl1_reg == $past(req.wdata))
    else $error("write to 05h not stored");

  a_write_ctl2: assert property (
    ce && req.wr && req.addr == `CHG_ADDR_CTL2 |=> ctl2_reg == $past(req.wdata))
    else $error("write to 06h not stored");

  a_write_ctl3: assert property (
    ce && req.wr && req.addr == `CHG_ADDR_CTL3 && !expire |=> ctl3_reg == $past(req.wdata))
    else $error("write to 07h not stored");

  a_read_vlim: assert property (
    ce && req.rd && req.addr == `CHG_ADDR_VLIM |=> rvalid && rdata == $past(vlim_reg))
    else $error("read of 04h returned wrong data");

  a_read_ctl2: assert property (
    ce && req.rd && req.addr == `CHG_ADDR_CTL2 |=> rvalid && rdata == $past(ctl2_reg))
    else $error("read of 06h returned wrong data");

  a_term_follow: assert property (
    ce && req.wr && req.addr == `CHG_ADDR_CTL1 && !expire |=> cfg.term_enable == $past(req.wdata[7]))
    else $error("termination enable does not follow bit 7");

  a_low_code: assert property (
    cfg.charge_voltage_code == 5'h00 |-> target.charge_regulation_voltage == 13'd3504)
    else $error("code 0 not 3.504 V");

  a_default_code: assert property (
    cfg.charge_voltage_code == 5'h08 |-> target.charge_regulation_voltage == 13'd4200)
    else $error("code 8 not 4.200 V");

  a_topup_off: assert property (
    cfg.topup_duration_select == 2'h0 |-> target.topup_minutes == 6'd0)
    else $error("top-off timer not disabled at code 0");

  a_topup_longest: assert property (
    cfg.topup_duration_select == 2'h3 |-> target.topup_minutes == 6'd45)
    else $error("top-off timer code 3 not 45 minutes");

  a_recharge_select: assert property (
    target.recharge_drop_mv == (cfg.recharge_threshold_select ? 8'd210 : 8'd120))
    else $error("recharge threshold wrong");

  a_wd_longest: assert property (
    cfg.watchdog_select == 2'h3 |-> target.watchdog_seconds == 8'd160)
    else $error("watchdog code 3 not 160 s");

  a_safety_off: assert property (
    !cfg.safety_timer_enable |-> target.precharge_hours == 5'd0 && target.fast_charge_hours == 5'd0)
    else $error("safety timers not both off");

  a_precharge_fixed: assert property (
    cfg.safety_timer_enable |-> target.precharge_hours == 5'd2)
    else $error("precharge timer not 2 hours");

  a_fast_timer: assert property (
    cfg.safety_timer_enable |-> target.fast_charge_hours == (cfg.fast_charge_timer_select ? 5'd10 : 5'd20))
    else $error("fast charge timer duration wrong");

  a_ovp_lowest: assert property (
    cfg.input_overvoltage_select == 2'h0 |-> target.overvoltage_mv == 15'd5850)
    else $error("overvoltage code 0 not 5.85 V");

  a_clear_single: assert property (
    ce && host_timeout_restart_clr |=> !host_timeout_restart_clr)
    else $error("restart clear longer than one cycle");

  a_fault_hold: assert property (
    ce && watchdog_fault && !restart |=> watchdog_fault)
    else $error("watchdog fault dropped without restart");

  a_expiry_ctl3: assert property (
    ce && expire |=> (ctl3_reg & `CHG_CTL3_WD_MASK) == (`CHG_RST_CTL3 & `CHG_CTL3_WD_MASK))
    else $error("watchdog bits of 07h not restored");

endmodule : chg_config_bank

// [chg_host_restart.sv]
// host-side model of the watchdog restart bit
`timescale 1ns/1ns

module chg_host_restart (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set_restart,
  input  wire logic restart_clr,
  output logic      host_timeout_restart
);
  logic restart_reg;
  logic restart_next;

  // host sets the bit, the device clear pulse drops it
  always_comb begin
    restart_next = restart_reg;
    if (restart_clr) restart_next = 1'b0;
    if (set_restart) restart_next = 1'b1;
  end

  // bit storage
  always_ff @(posedge clk) begin
    if (!rst_n) restart_reg <= 1'b0;
    else restart_reg <= restart_next;
  end

  assign host_timeout_restart = restart_reg;
endmodule : chg_host_restart

// [chg_tb.sv]
// self-checking bench for the charger configuration bank
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("Error %s expected %0h seen %0h", n, e, g); end end

module tb;
  logic                 clk;
  logic                 rst_n;
  logic                 ce;
  chg_pkg::chg_req_t    req;
  logic [7:0]           rdata;
  logic                 rvalid;
  logic                 restart;
  logic                 restart_clr;
  logic                 wd_expired;
  logic                 wd_fault;
  logic                 set_restart;
  chg_pkg::chg_cfg_t    cfg;
  chg_pkg::chg_target_t target;
  int                   num_errors;
  int                   checks_done;
  int                   expiries;
  int                   base;
  int                   n;
  int                   ovp_mv[4] = '{5850, 6400, 11000, 14200};
  int                   wd_s[4]   = '{0, 40, 80, 160};
  int                   charge_regulation_voltage_lo[9] = '{3504, 3600, 3696, 3800, 3904, 4000, 4100, 4150, 4200};

  chg_config_bank #(.TICK_CYCLES(10)) dut (
    .clk                      (clk),
    .rst_n                    (rst_n),
    .ce                       (ce),
    .req                      (req),
    .rdata                    (rdata),
    .rvalid                   (rvalid),
    .host_timeout_restart     (restart),
    .host_timeout_restart_clr (restart_clr),
    .watchdog_expired         (wd_expired),
    .watchdog_fault           (wd_fault),
    .cfg                      (cfg),
    .target                   (target)
  );

  chg_host_restart host (
    .clk                  (clk),
    .rst_n                (rst_n),
    .set_restart          (set_restart),
    .restart_clr          (restart_clr),
    .host_timeout_restart (restart)
  );

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // expiry pulse counter
  always @(posedge clk) begin
    if (wd_expired === 1'b1) expiries <= expiries + 1;
  end

  // register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask : wr

  // register read, data one cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask : rd

  // host restarts the watchdog and waits for the clear pulse
  task automatic kick();
    @(posedge clk);
    set_restart <= 1'b1;
    @(posedge clk);
    set_restart <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (restart_clr !== 1'b1 && n < 8);
    `CHK("restart_clr", 1'b1, restart_clr)
    @(posedge clk);
    #1;
    `CHK("restart bit", 1'b0, restart)
  endtask : kick

  // counts and verdict
  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("Error run_time expected done seen hang");
    results();
  end

  // test sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    req = '0;
    set_restart = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h04, 8'h40);
    rd(8'h05, 8'h9E);
    rd(8'h06, 8'hE6);
    rd(8'h07, 8'h4C);
    rd(8'h08, 8'h00);
    `CHK("term", 1'b1, cfg.term_enable)
    `CHK("charge_regulation_voltage", 13'd4200, target.charge_regulation_voltage)
    wr(8'h05, 8'h8E);
    $display("test reset done");
    wr(8'h04, 8'h00);
    `CHK("charge_regulation_voltage", 13'd3504, target.charge_regulation_voltage)
    wr(8'h04, 8'h48);
    `CHK("charge_regulation_voltage", 13'd4300, target.charge_regulation_voltage)
    wr(8'h04, 8'hF8);
    `CHK("charge_regulation_voltage", 13'd4520, target.charge_regulation_voltage)
    for (int c = 0; c < 9; c++) begin
      wr(8'h04, 8'(c << 3));
      `CHK("charge_regulation_voltage low", 13'(charge_regulation_voltage_lo[c]), target.charge_regulation_voltage)
    end
    for (int c = 9; c < 32; c++) begin
      wr(8'h04, 8'(c << 3));
      `CHK("charge_regulation_voltage lin", 13'(4300 + 10 * (c - 9)), target.charge_regulation_voltage)
    end
    wr(8'h04, 8'h41);
    `CHK("recharge", 8'd210, target.recharge_drop_mv)
    rd(8'h04, 8'h41);
    for (int c = 0; c < 4; c++) begin
      wr(8'h04, 8'(8'h40 | (c << 1)));
      `CHK("topup", 6'(15 * c), target.topup_minutes)
      `CHK("recharge", 8'd120, target.recharge_drop_mv)
    end
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h04, 8'h11);
    @(posedge clk);
    ce <= 1'b1;
    rd(8'h04, 8'h46);
    $display("test voltage limit done");
    wr(8'h05, 8'h0B);
    `CHK("term", 1'b0, cfg.term_enable)
    `CHK("precharge", 5'd2, target.precharge_hours)
    `CHK("fast", 5'd20, target.fast_charge_hours)
    `CHK("warm", 13'd4200, target.warm_charge_voltage)
    rd(8'h05, 8'h0B);
    wr(8'h05, 8'h84);
    `CHK("term", 1'b1, cfg.term_enable)
    `CHK("precharge", 5'd0, target.precharge_hours)
    `CHK("fast", 5'd0, target.fast_charge_hours)
    `CHK("warm", 13'd4100, target.warm_charge_voltage)
    wr(8'h05, 8'h8C);
    `CHK("fast", 5'd10, target.fast_charge_hours)
    for (int c = 0; c < 4; c++) begin
      wr(8'h05, 8'(8'h8E | (c << 4)));
      `CHK("wd period", 8'(wd_s[c]), target.watchdog_seconds)
    end
    wr(8'h05, 8'h8E);
    $display("test control one done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h06, 8'(c << 6));
      `CHK("ovp", 15'(ovp_mv[c]), target.overvoltage_mv)
    end
    for (int c = 0; c < 16; c++) begin
      wr(8'h06, 8'(c));
      `CHK("vin", 13'(3900 + 100 * c), target.input_limit_mv)
    end
    wr(8'h06, 8'h30);
    rd(8'h06, 8'h30);
    $display("test control two done");
    wr(8'h04, 8'hFF);
    wr(8'h07, 8'h00);
    wr(8'h05, 8'h9E);
    n = 0;
    while (wd_expired !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("expiry", 1'b1, wd_expired)
    `CHK("expiry time", 1'b1, (n > 394 && n < 406))
    `CHK("fault", 1'b1, wd_fault)
    rd(8'h04, 8'h40);
    rd(8'h05, 8'h9E);
    rd(8'h06, 8'h30);
    rd(8'h07, 8'h44);
    kick();
    `CHK("fault", 1'b0, wd_fault)
    $display("test watchdog expiry done");
    base = expiries;
    repeat (3) begin
      repeat (300) @(posedge clk);
      kick();
    end
    `CHK("expiries", base, expiries)
    `CHK("fault", 1'b0, wd_fault)
    $display("test watchdog restart done");
    results();
  end
endmodule : tb
